// ---- remap_input_pkg.sv ----
// constants and types for the input pin-routing register bank
`default_nettype none
package remap_input_pkg;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 16;
   localparam int unsigned SEL_W    = 5;
   localparam int unsigned RP_COUNT = 26;

   localparam logic [ADDR_W-1:0] IRQ1_ROUTE_OFS  = 8'h00;
   localparam logic [ADDR_W-1:0] IRQ2_ROUTE_OFS  = 8'h01;
   localparam logic [ADDR_W-1:0] TMR23_ROUTE_OFS = 8'h03;
   localparam logic [ADDR_W-1:0] OSC_CTRL_OFS    = 8'h20;

   localparam int unsigned IRQ1_LSB = 8;
   localparam int unsigned IRQ2_LSB = 0;
   localparam int unsigned TMR3_LSB = 8;
   localparam int unsigned TMR2_LSB = 0;
   localparam int unsigned LOCK_BIT = 6;

   localparam logic [SEL_W-1:0] SEL_RESET      = 5'h1f;
   localparam logic [7:0]       UNLOCK_KEY_ONE = 8'h46;
   localparam logic [7:0]       UNLOCK_KEY_TWO = 8'h57;
   localparam logic             PIN_IDLE_LEVEL = 1'b0;
   localparam logic [DATA_W-1:0] READ_ZERO     = 16'h0000;

   typedef struct packed {
      logic [SEL_W-1:0] irq1;
      logic [SEL_W-1:0] irq2;
      logic [SEL_W-1:0] tmr3;
      logic [SEL_W-1:0] tmr2;
   } route_sel_s;

   localparam route_sel_s ROUTE_RESET = '{irq1: SEL_RESET, irq2: SEL_RESET,
                                          tmr3: SEL_RESET, tmr2: SEL_RESET};

   typedef enum logic [1:0] {
      KEY_IDLE,
      KEY_FIRST,
      KEY_ARMED
   } unlock_e;
endpackage
`default_nettype wire

// ---- remap_input_select_bank.sv ----
// input pin-routing selection registers with keyed write lock and shadow check
// Function
// - Writes to routing registers are ignored unless the write lock is clear.
// - Full bank has 27 registers, 14 input and 13 output selects.
// - First input register bits 12:8 select pin for interrupt one.
// - Second input register bits 4:0 select pin for interrupt two.
// - Timer clock register bits 12:8 select pin for timer three clock.
// - Timer clock register bits 4:0 select pin for timer two clock.
// - Unimplemented bits read zero and ignore writes.
// - With one-session fuse set, lock cannot be cleared once set.
// - Routing registers are compared with shadows; mismatch raises reset.
// - After reset all selects read all ones and lock is clear.
//
// Implementation choices: the placing of the registers and strobed register access.
`default_nettype none
module remap_input_select_bank
   import remap_input_pkg::*;
(
   input  wire logic                mclk_i,
   input  wire logic                nrst_i,
   input  wire logic [ADDR_W-1:0]   addr_i,
   input  wire logic [DATA_W-1:0]   wdata_i,
   input  wire logic                wr_i,
   input  wire logic                rd_i,
   output logic      [DATA_W-1:0]   rdata_o,
   input  wire logic                single_session_lock_fuse_i,
   input  wire logic [RP_COUNT-1:0] rp_pins_i,
   output logic                     external_irq_one_o,
   output logic                     external_irq_two_o,
   output logic                     timer3_ext_clock_o,
   output logic                     timer2_ext_clock_o,
   output logic                     route_write_lock_o,
   output logic                     config_mismatch_rst_o
);

   // reset release synchroniser
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   function automatic logic route_pin(input logic [SEL_W-1:0]    sel,
                                      input logic [RP_COUNT-1:0] pins);
      logic lvl;
      lvl = PIN_IDLE_LEVEL;
      if (32'(sel) < RP_COUNT) begin
         lvl = pins[sel];
      end
      return lvl;
   endfunction

   function automatic logic [DATA_W-1:0] place(input logic [SEL_W-1:0] f,
                                               input int unsigned      lsb);
      return DATA_W'({11'h000, f} << lsb);
   endfunction

   // register state
   route_sel_s        sel_q, sel_d;
   route_sel_s        shadow_q, shadow_d;
   logic              lock_q, lock_d;
   logic              locked_once_q, locked_once_d;
   unlock_e           key_q, key_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic              mismatch_q, mismatch_d;
   logic              irq1_q, irq1_d;
   logic              irq2_q, irq2_d;
   logic              tmr3_q, tmr3_d;
   logic              tmr2_q, tmr2_d;

   logic       osc_wr;
   logic       route_wr;
   logic [7:0] key_byte;

   assign osc_wr   = wr_i && (addr_i == OSC_CTRL_OFS);
   assign route_wr = wr_i && !lock_q;
   assign key_byte = wdata_i[7:0];

   // unlock sequence and lock bit
   always_comb begin
      key_d         = key_q;
      lock_d        = lock_q;
      locked_once_d = locked_once_q;
      if (osc_wr) begin
         case (key_q)
            KEY_IDLE: begin
               key_d = (key_byte == UNLOCK_KEY_ONE) ? KEY_FIRST : KEY_IDLE;
            end
            KEY_FIRST: begin
               if (key_byte == UNLOCK_KEY_TWO) begin
                  key_d = KEY_ARMED;
               end else if (key_byte == UNLOCK_KEY_ONE) begin
                  key_d = KEY_FIRST;
               end else begin
                  key_d = KEY_IDLE;
               end
            end
            KEY_ARMED: begin
               key_d = KEY_IDLE;
               // one-session fuse pins the lock once it was ever set
               if (!(single_session_lock_fuse_i && locked_once_q &&
                     !wdata_i[LOCK_BIT])) begin
                  lock_d = wdata_i[LOCK_BIT];
               end
            end
            default: key_d = KEY_IDLE;
         endcase
      end else if (wr_i) begin
         // any other write breaks the key sequence
         key_d = KEY_IDLE;
      end
      locked_once_d = locked_once_q | lock_d;
   end

   // selection fields and their shadows
   always_comb begin
      sel_d = sel_q;
      if (route_wr) begin
         case (addr_i)
            IRQ1_ROUTE_OFS: sel_d.irq1 = wdata_i[IRQ1_LSB +: SEL_W];
            IRQ2_ROUTE_OFS: sel_d.irq2 = wdata_i[IRQ2_LSB +: SEL_W];
            TMR23_ROUTE_OFS: begin
               sel_d.tmr3 = wdata_i[TMR3_LSB +: SEL_W];
               sel_d.tmr2 = wdata_i[TMR2_LSB +: SEL_W];
            end
            default: sel_d = sel_q;
         endcase
      end
      // shadows load sel_d like the selects, so an upset shows as a difference for one cycle
      shadow_d   = sel_d;
      mismatch_d = mismatch_q | (sel_q != shadow_q);
   end

   // readback; only three of the bank's 27 registers live here
   always_comb begin
      rdata_d = READ_ZERO;
      if (rd_i) begin
         case (addr_i)
            IRQ1_ROUTE_OFS:  rdata_d = place(sel_q.irq1, IRQ1_LSB);
            IRQ2_ROUTE_OFS:  rdata_d = place(sel_q.irq2, IRQ2_LSB);
            TMR23_ROUTE_OFS: rdata_d = place(sel_q.tmr3, TMR3_LSB) |
                                       place(sel_q.tmr2, TMR2_LSB);
            OSC_CTRL_OFS:    rdata_d = DATA_W'({15'h0000, lock_q} << LOCK_BIT);
            default:         rdata_d = READ_ZERO;
         endcase
      end
   end

   // peripheral input routing
   always_comb begin
      irq1_d = route_pin(sel_q.irq1, rp_pins_i);
      irq2_d = route_pin(sel_q.irq2, rp_pins_i);
      tmr3_d = route_pin(sel_q.tmr3, rp_pins_i);
      tmr2_d = route_pin(sel_q.tmr2, rp_pins_i);
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         sel_q         <= ROUTE_RESET;
         shadow_q      <= ROUTE_RESET;
         lock_q        <= 1'b0;
         locked_once_q <= 1'b0;
         key_q         <= KEY_IDLE;
         rdata_q       <= READ_ZERO;
         mismatch_q    <= 1'b0;
         irq1_q        <= PIN_IDLE_LEVEL;
         irq2_q        <= PIN_IDLE_LEVEL;
         tmr3_q        <= PIN_IDLE_LEVEL;
         tmr2_q        <= PIN_IDLE_LEVEL;
      end else begin
         sel_q         <= sel_d;
         shadow_q      <= shadow_d;
         lock_q        <= lock_d;
         locked_once_q <= locked_once_d;
         key_q         <= key_d;
         rdata_q       <= rdata_d;
         mismatch_q    <= mismatch_d;
         irq1_q        <= irq1_d;
         irq2_q        <= irq2_d;
         tmr3_q        <= tmr3_d;
         tmr2_q        <= tmr2_d;
      end
   end

   assign rdata_o               = rdata_q;
   assign route_write_lock_o    = lock_q;
   assign config_mismatch_rst_o = mismatch_q;
   assign external_irq_one_o    = irq1_q;
   assign external_irq_two_o    = irq2_q;
   assign timer3_ext_clock_o    = tmr3_q;
   assign timer2_ext_clock_o    = tmr2_q;

   blocked_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      wr_i && lock_q |=> $stable(sel_q))
      else $error("routing changed while locked");

   irq1_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      wr_i && !lock_q && addr_i == IRQ1_ROUTE_OFS
      |=> sel_q.irq1 == $past(wdata_i[12:8]) && $stable(sel_q.irq2))
      else $error("interrupt one select not written");

   irq2_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      rd_i && addr_i == IRQ2_ROUTE_OFS |=> rdata_o == {11'h000, $past(sel_q.irq2)})
      else $error("interrupt two readback wrong");

   timer_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      wr_i && !lock_q && addr_i == TMR23_ROUTE_OFS
      |=> sel_q.tmr3 == $past(wdata_i[12:8]) && sel_q.tmr2 == $past(wdata_i[4:0]))
      else $error("timer clock selects not written");

   unused_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      rd_i && addr_i == IRQ1_ROUTE_OFS |=> rdata_o[15:13] == 3'h0 && rdata_o[7:0] == 8'h00)
      else $error("unimplemented bits not zero");

   reset_value_a: assert property (@(posedge mclk_i)
      $rose(rst_n) |-> sel_q == ROUTE_RESET && !lock_q)
      else $error("bad reset state");

   key_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      $changed(lock_q) |-> $past(key_q) == KEY_ARMED && $past(osc_wr))
      else $error("lock changed without key sequence");

   fuse_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      single_session_lock_fuse_i && locked_once_q && lock_q |=> lock_q)
      else $error("lock cleared despite fuse");

   shadow_match_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      sel_q != shadow_q |=> config_mismatch_rst_o)
      else $error("mismatch not flagged");

   route_pin_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      32'(sel_q.irq1) >= RP_COUNT |=> external_irq_one_o == PIN_IDLE_LEVEL)
      else $error("missing pin not held idle");

endmodule // remap_input_select_bank
`default_nettype wire

// ---- remap_input_select_bank_test.sv ----
// self-checking bench for the input pin-routing register bank
`default_nettype none
module remap_input_select_bank_test
   import remap_input_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic                mclk_i  = 1'b0;
   logic                nrst_i  = 1'b0;
   logic [ADDR_W-1:0]   addr_i  = 8'h00;
   logic [DATA_W-1:0]   wdata_i = 16'h0000;
   logic                wr_i    = 1'b0;
   logic                rd_i    = 1'b0;
   logic                fuse    = 1'b0;
   logic [RP_COUNT-1:0] pins    = 26'h0;
   logic [DATA_W-1:0]   rdata_o;
   logic                irq1_o, irq2_o, t3_o, t2_o, lock_o, mism_o;
   logic [31:0]         seed    = 32'h3d;
   logic [SEL_W-1:0]    s1, s2, s3, s4;
   logic                mlock, once;
   logic [DATA_W-1:0]   d;
   int                  num_errors  = 0;
   int                  check_count = 0;

   always #5 mclk_i = ~mclk_i;

   remap_input_select_bank uut (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .single_session_lock_fuse_i(fuse),
      .rp_pins_i(pins), .external_irq_one_o(irq1_o), .external_irq_two_o(irq2_o),
      .timer3_ext_clock_o(t3_o), .timer2_ext_clock_o(t2_o),
      .route_write_lock_o(lock_o), .config_mismatch_rst_o(mism_o));

   task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // codes past the last pin must give the idle level, not wrap
   function automatic logic route(input logic [SEL_W-1:0] s);
      return (s < RP_COUNT) ? pins[s] : PIN_IDLE_LEVEL;
   endfunction

   task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge mclk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
   endtask

   task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge mclk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
      #1;
      check("rdata", rdata_o, exp);
   endtask

   task automatic wr_sel(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      reg_wr(a, v);
      if (!mlock && a == IRQ1_ROUTE_OFS) s1 = v[IRQ1_LSB +: SEL_W];
      if (!mlock && a == IRQ2_ROUTE_OFS) s2 = v[IRQ2_LSB +: SEL_W];
      if (!mlock && a == TMR23_ROUTE_OFS) begin
         s3 = v[TMR3_LSB +: SEL_W];
         s4 = v[TMR2_LSB +: SEL_W];
      end
   endtask

   task automatic chk_all();
      reg_rd(IRQ1_ROUTE_OFS, {3'h0, s1, 8'h00});
      reg_rd(IRQ2_ROUTE_OFS, {11'h000, s2});
      reg_rd(TMR23_ROUTE_OFS, {3'h0, s3, 3'h0, s4});
      @(posedge mclk_i);
      pins <= RP_COUNT'(xorshift());
      @(posedge mclk_i);
      #1;
      check("irq1", irq1_o, route(s1));
      check("irq2", irq2_o, route(s2));
      check("tmr3", t3_o, route(s3));
      check("tmr2", t2_o, route(s4));
      check("mismatch", mism_o, 1'b0);
   endtask

   task automatic set_lock(input logic v);
      reg_wr(OSC_CTRL_OFS, 16'h0046);
      reg_wr(OSC_CTRL_OFS, 16'h0057);
      reg_wr(OSC_CTRL_OFS, DATA_W'(v) << LOCK_BIT);
      if (v || !(fuse && once)) mlock = v;
      once = once | mlock;
      #1;
      check("lock", lock_o, mlock);
   endtask

   task automatic do_reset();
      @(posedge mclk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      {s1, s2, s3, s4} = ROUTE_RESET;
      mlock = 1'b0;
      once  = 1'b0;
      chk_all();
      check("lock", lock_o, 1'b0);
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic rand_round();
      for (int i = 0; i < 12; i++) begin
         d = 16'(xorshift());
         if (i < 4) d[12:8] = (i == 0) ? 5'h00 : (i == 1) ? 5'h19 : (i == 2) ? 5'h1a : 5'h1f;
         if (i < 4) d[4:0]  = d[12:8];
         wr_sel(IRQ1_ROUTE_OFS, d);
         wr_sel(IRQ2_ROUTE_OFS, {d[7:0], d[15:8]});
         wr_sel(TMR23_ROUTE_OFS, ~d);
         chk_all();
      end
   endtask

   initial begin
      repeat (2) @(posedge mclk_i);
      do_reset();
      reg_rd(OSC_CTRL_OFS, 16'h0000);
      reg_rd(8'h05, 16'h0000);
      rand_round();
      set_lock(1'b1);
      rand_round();
      // interrupted key sequence must not reach the lock
      reg_wr(OSC_CTRL_OFS, 16'h0046);
      wr_sel(IRQ2_ROUTE_OFS, 16'h0003);
      reg_wr(OSC_CTRL_OFS, 16'h0057);
      reg_wr(OSC_CTRL_OFS, 16'h0000);
      #1;
      check("lock", lock_o, 1'b1);
      // repeated first key must keep the sequence alive
      reg_wr(OSC_CTRL_OFS, 16'h0046);
      set_lock(1'b0);
      rand_round();
      @(posedge mclk_i);
      fuse <= 1'b1;
      set_lock(1'b1);
      set_lock(1'b0);
      reg_rd(OSC_CTRL_OFS, 16'h0040);
      rand_round();
      do_reset();
      set_lock(1'b0);
      rand_round();
      conclude();
   end

   initial begin
      #50us;
      num_errors++;
      conclude();
   end
endmodule // remap_input_select_bank_test
`default_nettype wire
